// *** shared/clk_switch_pkg.sv ***
// Purpose: Constants, types and helpers of the clock switch and fail monitor
// Assumes: One system clock of 100 MHz; oscillator clocks arrive as raw pins
// Notes: Source codes fill the 3-bit requested and current source fields
package clk_switch_pkg;

   // Source codes
   localparam logic [2:0] SRC_FRC = 3'h0;
   localparam logic [2:0] SRC_FRC_PLL = 3'h1;
   localparam logic [2:0] SRC_PRI = 3'h2;
   localparam logic [2:0] SRC_PRI_PLL = 3'h3;
   localparam logic [2:0] SRC_LP = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC_OSC = 3'h5;

   // Primary sub-modes
   localparam logic [1:0] SUB_EXT = 2'h0;
   localparam logic [1:0] SUB_XTAL = 2'h1;
   localparam logic [1:0] SUB_HS_XTAL = 2'h2;

   // Oscillator index in the clock vector, and enable vector bits
   localparam logic [1:0] OSC_PRI = 2'h0;
   localparam logic [1:0] OSC_LP = 2'h1;
   localparam logic [1:0] OSC_FRC = 2'h2;
   localparam logic [1:0] OSC_LOW_POWER_RC_OSC = 2'h3;
   localparam int EN_PLL = 4;
   localparam int EN_W = 5;

   // Control register layout
   localparam int CTL_REQ = 0;
   localparam int CTL_KEEP = 1;
   localparam int CTL_CF = 3;
   localparam int CTL_LOCK = 5;
   localparam int CTL_REQUESTED_SOURCE_SEL_LO = 8;
   localparam int CTL_CURRENT_SOURCE_SEL_LO = 12;

   // Counts of oscillator edges
   localparam int OST_W = 10;
   localparam logic [OST_W-1:0] OST_EDGES = 10'h3ff;
   localparam logic [3:0] SETTLE_EDGES = 4'ha;
   localparam logic [2:0] FAIL_LOW_POWER_RC_OSC_EDGES = 3'h4;

   typedef enum logic [1:0] {ST_IDLE, ST_OST, ST_LOCK, ST_SETTLE} sw_state_t;

   function automatic logic [1:0] osc_of(input logic [2:0] src);
      case (src)
         SRC_PRI, SRC_PRI_PLL: osc_of = OSC_PRI;
         SRC_LP: osc_of = OSC_LP;
         SRC_LOW_POWER_RC_OSC: osc_of = OSC_LOW_POWER_RC_OSC;
         default: osc_of = OSC_FRC;
      endcase
   endfunction

   function automatic logic uses_pll(input logic [2:0] src);
      uses_pll = (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
   endfunction

   function automatic logic valid_src(input logic [2:0] src);
      valid_src = (src <= SRC_LOW_POWER_RC_OSC);
   endfunction

endpackage

// *** core/sync_two_ff.sv ***
// Purpose: Two flip-flop synchroniser for a vector of unrelated levels
// Assumes: Each bit is independent; no bus coherence is needed
// Notes: Only the second stage is visible outside
module sync_two_ff #(
   parameter int WIDTH = 5
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // Levels
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } sync_state_t;

   sync_state_t s_r;
   sync_state_t s_nxt;

   always_comb begin
      s_nxt.s1 = async_i;
      s_nxt.s2 = s_r.s1;
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sync_o = s_r.s2;

endmodule

// *** core/clock_switch_failsafe_monitor.sv ***
// Purpose: Oscillator selection, clock switching and fail-safe clock monitor
// Assumes: Fuse inputs are static; reset pulses come from logic on clk_sys_i
// Notes: Oscillator clocks and PLL lock are sampled through two flip-flops
module clock_switch_failsafe_monitor
   import clk_switch_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // Configuration fuses
   input wire logic switch_enable_fuse_i,
   input wire logic [2:0] initial_source_fuse_i,
   input wire logic [1:0] primary_submode_cfg_i,
   // Control register byte writes
   input wire logic unlock_hi_i,
   input wire logic unlock_lo_i,
   input wire logic wr_hi_i,
   input wire logic wr_lo_i,
   input wire logic [7:0] wr_data_i,
   // System events
   input wire logic soft_reset_i,
   input wire logic wdt_reset_i,
   input wire logic wdt_enable_i,
   input wire logic sleep_i,
   // Oscillators and PLL
   input wire logic [3:0] osc_clk_i,
   input wire logic pll_lock_i,
   // Status and control outputs
   output logic [15:0] osc_control_reg_o,
   output logic [2:0] clk_select_o,
   output logic [1:0] primary_submode_o,
   output logic [EN_W-1:0] osc_enable_o,
   output logic clock_fail_trap_o,
   output logic switch_busy_o
);

   typedef struct packed {
      logic booted;
      logic [2:0] current_source_sel;
      logic [2:0] requested_source_sel;
      logic req;
      logic keep_on;
      logic cf;
      logic lock;
      logic arm_hi;
      logic arm_lo;
      sw_state_t st;
      logic [OST_W-1:0] ost_cnt;
      logic [3:0] settle_cnt;
      logic [2:0] fail_cnt;
      logic [3:0] clk_prev;
      logic trap;
      logic [EN_W-1:0] osc_en;
      logic [1:0] submode;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   logic [4:0] sync_out;
   logic [3:0] clk_s;
   logic [3:0] edge_s;
   logic lock_s;
   logic sw_on;
   logic sw_reset;
   logic fail_hit;
   logic new_edge;

   sync_two_ff #(.WIDTH(5)) u_sync (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .async_i({pll_lock_i, osc_clk_i}),
      .sync_o(sync_out)
   );

   assign clk_s = sync_out[3:0];
   assign lock_s = sync_out[4];
   assign edge_s = clk_s & ~s_r.clk_prev;
   assign sw_on = !switch_enable_fuse_i;
   assign sw_reset = soft_reset_i | wdt_reset_i;
   assign new_edge = edge_s[osc_of(s_r.requested_source_sel)];
   assign fail_hit = sw_on && !sleep_i && (s_r.current_source_sel != SRC_LOW_POWER_RC_OSC)
                     && (s_r.fail_cnt == FAIL_LOW_POWER_RC_OSC_EDGES);

   always_comb begin
      s_nxt = s_r;
      s_nxt.clk_prev = clk_s;
      s_nxt.trap = 1'b0;
      s_nxt.submode = primary_submode_cfg_i;
      s_nxt.lock = lock_s;
      s_nxt.arm_hi = unlock_hi_i;
      s_nxt.arm_lo = unlock_lo_i;
      if (!s_r.booted) begin
         s_nxt.booted = 1'b1;
         s_nxt.current_source_sel = initial_source_fuse_i;
         s_nxt.requested_source_sel = initial_source_fuse_i;
      end
      // Byte writes, each only right after its own unlock
      if (wr_hi_i && s_r.arm_hi) begin
         s_nxt.requested_source_sel = wr_data_i[2:0];
      end
      if (wr_lo_i && s_r.arm_lo) begin
         s_nxt.keep_on = wr_data_i[CTL_KEEP];
         if (wr_data_i[CTL_REQ]) begin
            s_nxt.req = 1'b1;
         end
         if (!wr_data_i[CTL_CF]) begin
            s_nxt.cf = 1'b0;
         end
      end
      if (!sw_on) begin
         s_nxt.current_source_sel = initial_source_fuse_i;
         s_nxt.req = 1'b0;
         s_nxt.st = ST_IDLE;
      end else begin
         case (s_r.st)
            ST_IDLE: begin
               if (s_r.req) begin
                  if (s_r.requested_source_sel == s_r.current_source_sel || !valid_src(s_r.requested_source_sel)) begin
                     s_nxt.req = 1'b0;
                  end else begin
                     s_nxt.lock = 1'b0;
                     s_nxt.cf = 1'b0;
                     s_nxt.ost_cnt = '0;
                     s_nxt.settle_cnt = '0;
                     if (osc_of(s_r.requested_source_sel) == OSC_LP || (osc_of(s_r.requested_source_sel) == OSC_PRI
                         && primary_submode_cfg_i != SUB_EXT)) begin
                        s_nxt.st = ST_OST;
                     end else if (uses_pll(s_r.requested_source_sel)) begin
                        s_nxt.st = ST_LOCK;
                     end else begin
                        s_nxt.st = ST_SETTLE;
                     end
                  end
               end
            end
            ST_OST: begin
               if (s_r.ost_cnt == OST_EDGES) begin
                  s_nxt.st = uses_pll(s_r.requested_source_sel) ? ST_LOCK : ST_SETTLE;
               end else if (new_edge) begin
                  s_nxt.ost_cnt = s_r.ost_cnt + 1'b1;
               end
            end
            ST_LOCK: begin
               if (s_r.lock) begin
                  s_nxt.st = ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               if (new_edge) begin
                  if (s_r.settle_cnt == SETTLE_EDGES - 4'h1) begin
                     s_nxt.current_source_sel = s_r.requested_source_sel;
                     s_nxt.req = 1'b0;
                     s_nxt.st = ST_IDLE;
                  end else begin
                     s_nxt.settle_cnt = s_r.settle_cnt + 4'h1;
                  end
               end
            end
            default: s_nxt.st = ST_IDLE;
         endcase
      end
      // Fail monitor: LOW_POWER_RC_OSC edges since the last edge of the running clock
      if (!sw_on || sleep_i || edge_s[osc_of(s_r.current_source_sel)]) begin
         s_nxt.fail_cnt = '0;
      end else if (edge_s[OSC_LOW_POWER_RC_OSC] && !fail_hit) begin
         s_nxt.fail_cnt = s_r.fail_cnt + 3'h1;
      end
      if (fail_hit) begin
         s_nxt.cf = 1'b1;
         s_nxt.trap = 1'b1;
         s_nxt.current_source_sel = uses_pll(s_r.current_source_sel) ? SRC_FRC_PLL : SRC_FRC;
         s_nxt.req = 1'b0;
         s_nxt.st = ST_IDLE;
         s_nxt.fail_cnt = '0;
      end
      // Soft and watchdog resets abort a switch but keep the selection, except in a cycle where a clock failure also hits
      if (sw_reset) begin
         if (sw_on && s_r.booted && !fail_hit) begin
            s_nxt.current_source_sel = s_r.current_source_sel;
         end
         s_nxt.req = 1'b0;
         s_nxt.st = ST_IDLE;
         s_nxt.arm_hi = 1'b0;
         s_nxt.arm_lo = 1'b0;
      end
      // Oscillator enables follow the next state
      s_nxt.osc_en = '0;
      s_nxt.osc_en[osc_of(s_nxt.current_source_sel)] = 1'b1;
      if (s_nxt.st != ST_IDLE) begin
         s_nxt.osc_en[osc_of(s_nxt.requested_source_sel)] = 1'b1;
      end
      s_nxt.osc_en[EN_PLL] = uses_pll(s_nxt.current_source_sel)
                             || (s_nxt.st != ST_IDLE && uses_pll(s_nxt.requested_source_sel));
      if (s_nxt.keep_on) begin
         s_nxt.osc_en[OSC_LP] = 1'b1;
      end
      if ((sw_on || wdt_enable_i) && !sleep_i) begin
         s_nxt.osc_en[OSC_LOW_POWER_RC_OSC] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs: the core is never stalled by a switch
   assign osc_control_reg_o = {1'b0, s_r.current_source_sel, 1'b0, s_r.requested_source_sel, 2'b00, s_r.lock,
                               1'b0, s_r.cf, 1'b0, s_r.keep_on, s_r.req};
   assign clk_select_o = s_r.current_source_sel;
   assign primary_submode_o = s_r.submode;
   assign osc_enable_o = s_r.osc_en;
   assign clock_fail_trap_o = s_r.trap;
   assign switch_busy_o = (s_r.st != ST_IDLE);

   // Checks
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rstn_i);

   req_off_disabled_a: assert property (!sw_on |=> !osc_control_reg_o[CTL_REQ])
      else $error("request bit set while switching disabled");
   current_source_sel_fuse_a: assert property (!sw_on |=> clk_select_o == $past(initial_source_fuse_i))
      else $error("current source does not follow fuse");
   redundant_abort_a: assert property (sw_on && s_r.st == ST_IDLE && s_r.req
      && s_r.requested_source_sel == s_r.current_source_sel |=> !s_r.req && s_r.st == ST_IDLE)
      else $error("redundant switch not aborted");
   start_clear_a: assert property (sw_on && s_r.st == ST_IDLE && s_r.req && !fail_hit
      && !sw_reset && s_r.requested_source_sel != s_r.current_source_sel && valid_src(s_r.requested_source_sel)
      |=> !s_r.cf && !s_r.lock && s_r.st != ST_IDLE)
      else $error("switch start did not clear status");
   lock_wait_a: assert property (s_r.st == ST_LOCK && !s_r.lock && sw_on && !sw_reset
      && !fail_hit |=> s_r.st == ST_LOCK)
      else $error("left lock wait without lock");
   settle_done_a: assert property (sw_on && $past(sw_on) && $past(s_r.st) == ST_SETTLE
      && s_r.st == ST_IDLE && !$past(fail_hit) && !$past(sw_reset)
      |-> $past(s_r.settle_cnt) == SETTLE_EDGES - 4'h1 && s_r.current_source_sel == s_r.requested_source_sel
      && !s_r.req)
      else $error("switch completed without ten new-clock edges");
   ost_enable_a: assert property (s_r.st == ST_OST && $past(s_r.st) == ST_OST
      |-> osc_enable_o[osc_of(s_r.requested_source_sel)])
      else $error("requested oscillator not enabled");
   low_power_rc_osc_on_a: assert property (sw_on && !sleep_i |=> osc_enable_o[OSC_LOW_POWER_RC_OSC])
      else $error("LOW_POWER_RC_OSC stopped while monitor enabled");
   fail_fallback_a: assert property (fail_hit |=> clock_fail_trap_o && s_r.cf
      && clk_select_o == (uses_pll($past(s_r.current_source_sel)) ? SRC_FRC_PLL : SRC_FRC))
      else $error("clock failure not handled");
   keep_sel_a: assert property (sw_reset && sw_on && s_r.booted && !fail_hit
      |=> $stable(clk_select_o) && !s_r.req)
      else $error("reset pulse changed the clock selection");
   locked_write_a: assert property (wr_hi_i && !s_r.arm_hi && s_r.booted
      |=> $stable(s_r.requested_source_sel))
      else $error("write accepted without unlock");

   switch_done_c: cover property (s_r.st == ST_SETTLE ##1 s_r.st == ST_IDLE && !s_r.req);
   redundant_c: cover property (s_r.st == ST_IDLE && s_r.req && s_r.requested_source_sel == s_r.current_source_sel);
   fail_c: cover property (fail_hit);
   pll_switch_c: cover property (s_r.st == ST_LOCK ##1 s_r.st == ST_SETTLE);

endmodule

// *** sim/test_clock_switch_failsafe_monitor.sv ***
// Purpose: Self-checking bench of the clock switch and fail-safe monitor
// Assumes: Oscillators are divided copies of the system clock, gated by osc_enable_o
// Notes: Driver notes expectations in a queue; a monitor process compares them
module test_clock_switch_failsafe_monitor
   import clk_switch_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [27:0] val; logic [27:0] mask;} note_t;
   logic clk_sys_i;
   logic rstn_i;
   logic fuse;
   logic [2:0] init_src;
   logic [1:0] submode;
   logic unl_hi, unl_lo, wr_hi, wr_lo;
   logic [7:0] wdata;
   logic soft_rst, wdt_rst, wdt_en, sleep;
   logic [3:0] osc_clk = 4'h0;
   logic pll_lock = 1'b0;
   logic [15:0] ctl;
   logic [2:0] sel;
   logic [1:0] sub_o;
   logic [EN_W-1:0] osc_en;
   logic trap, busy;
   logic [3:0] alive = 4'hf;
   logic pll_ok = 1'b0;
   int half [4] = '{2, 2, 2, 8};
   int div [4] = '{0, 0, 0, 0};
   int seed = 81;
   int error_cnt = 0;
   int checks_done = 0;
   note_t notes [$];
   event note_ev;
   wire [27:0] obs = {osc_en, trap, busy, sel, sub_o, ctl};

   clock_switch_failsafe_monitor i_clock_switch_failsafe_monitor (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .switch_enable_fuse_i(fuse),
      .initial_source_fuse_i(init_src), .primary_submode_cfg_i(submode),
      .unlock_hi_i(unl_hi), .unlock_lo_i(unl_lo), .wr_hi_i(wr_hi), .wr_lo_i(wr_lo),
      .wr_data_i(wdata), .soft_reset_i(soft_rst), .wdt_reset_i(wdt_rst),
      .wdt_enable_i(wdt_en), .sleep_i(sleep), .osc_clk_i(osc_clk), .pll_lock_i(pll_lock),
      .osc_control_reg_o(ctl), .clk_select_o(sel), .primary_submode_o(sub_o),
      .osc_enable_o(osc_en), .clock_fail_trap_o(trap), .switch_busy_o(busy));

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // Enabled and alive oscillators toggle every half[i] falling edges
   always @(negedge clk_sys_i) begin
      for (int i = 0; i < 4; i++) begin
         if (osc_en[i] === 1'b1 && alive[i]) begin
            div[i] = div[i] + 1;
            if (div[i] >= half[i]) begin
               div[i] = 0;
               osc_clk[i] <= ~osc_clk[i];
            end
         end
      end
      pll_lock <= (osc_en[EN_PLL] === 1'b1) && pll_ok;
   end

   // Monitor: drains the queue whenever a note is posted
   initial begin
      note_t n;
      forever begin
         @(note_ev);
         while (notes.size() > 0) begin
            n = notes.pop_front();
            checks_done++;
            if (((obs ^ n.val) & n.mask) !== 28'h0) begin
               error_cnt++;
               $display("[ERR] t=%0t got=%h exp=%h mask=%h", $time, obs, n.val, n.mask);
            end
         end
      end
   end

   task automatic end_of_test();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic timeout(input logic [27:0] got);
      error_cnt++;
      $display("[ERR] t=%0t wait bound used up got=%h exp=%h", $time, got, 28'h0);
      end_of_test();
   endtask

   task automatic note(input logic [27:0] val, input logic [27:0] mask);
      notes.push_back('{val, mask});
      -> note_ev;
   endtask

   task automatic note_cur(input logic [2:0] code);
      note({7'h0, code, 2'h0, 1'b0, code, 12'h0}, {7'h0, 3'h7, 2'h0, 16'h7000});
   endtask

   task automatic note_ctl(input logic [15:0] v, input logic [15:0] m);
      note({12'h0, v}, {12'h0, m});
   endtask

   task automatic note_en(input logic [4:0] v, input logic [4:0] m);
      note({v, 23'h0}, {m, 23'h0});
   endtask

   task automatic chk_min(input int got, input int lo);
      checks_done++;
      if (got < lo) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp_min=%h", $time, got, lo);
      end
   endtask

   task automatic do_reset(input logic f, input logic [2:0] src);
      rstn_i = 1'b0;
      fuse = f;
      init_src = src;
      repeat (4) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      repeat (2) @(negedge clk_sys_i);
   endtask

   task automatic wr_byte(input logic hi, input logic [7:0] d, input logic unl);
      unl_hi = hi & unl;
      unl_lo = ~hi & unl;
      @(negedge clk_sys_i);
      unl_hi = 1'b0;
      unl_lo = 1'b0;
      wr_hi = hi;
      wr_lo = ~hi;
      wdata = d;
      @(negedge clk_sys_i);
      wr_hi = 1'b0;
      wr_lo = 1'b0;
   endtask

   task automatic request(input logic [2:0] code, input logic [7:0] lo);
      logic [7:0] r;
      r = $random(seed);
      repeat (1 + (r & 8'h03)) @(negedge clk_sys_i);
      wr_byte(1'b1, {r[7:3], code}, 1'b1);
      wr_byte(1'b0, lo, 1'b1);
   endtask

   task automatic wait_idle(input int max, output int n);
      n = 0;
      while (busy !== 1'b0 && n < max) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n >= max) timeout(obs);
   endtask

   task automatic switch_to(input logic [2:0] code, input logic [7:0] lo, input int b,
                            input int lo_n, input int hi_n);
      int n;
      request(code, lo);
      @(negedge clk_sys_i);
      note({5'h1 << b, 2'h1, 21'h0}, {5'h1 << b, 2'h1, 5'h0, 16'h0028});
      wait_idle(hi_n, n);
      chk_min(n, lo_n);
      note_cur(code);
      note_ctl(16'h0000, 16'h0001);
   endtask

   initial begin
      int n;
      {unl_hi, unl_lo, wr_hi, wr_lo, soft_rst, wdt_rst, wdt_en, sleep} = 8'h00;
      wdata = 8'h00;
      submode = SUB_HS_XTAL;
      // Switching disabled by the fuse
      do_reset(1'b1, SRC_LP);
      note_cur(SRC_LP);
      note({10'h0, SUB_HS_XTAL, 16'h0}, {10'h0, 2'h3, 16'h0});
      request(SRC_FRC, 8'h01);
      note_ctl({5'h0, SRC_FRC, 8'h00}, 16'h0701);
      repeat (40) @(negedge clk_sys_i);
      note_cur(SRC_LP);
      note_en(5'h00, 5'h08);
      wdt_en = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      note_en(5'h08, 5'h08);
      wdt_en = 1'b0;
      // Switching enabled
      submode = SUB_EXT;
      do_reset(1'b0, SRC_FRC);
      note_cur(SRC_FRC);
      note_en(5'h0c, 5'h0c);
      wr_byte(1'b1, {5'h0, SRC_LOW_POWER_RC_OSC}, 1'b0);
      note_ctl(16'h0000, 16'h0700);
      request(SRC_FRC, 8'h01);
      repeat (2) @(negedge clk_sys_i);
      note({6'h0, 1'b0, 5'h0, 16'h0}, {6'h0, 1'b1, 5'h0, 16'h0001});
      switch_to(SRC_LOW_POWER_RC_OSC, 8'h01, OSC_LOW_POWER_RC_OSC, 140, 400);
      note_en(5'h08, 5'h0c);
      fork
         begin
            repeat (120) @(negedge clk_sys_i);
            pll_ok = 1'b1;
         end
      join_none
      switch_to(SRC_PRI_PLL, 8'h01, OSC_PRI, 100, 600);
      note_en(5'h18, 5'h18);
      note({10'h0, SUB_EXT, 16'h0}, {10'h0, 2'h3, 16'h0});
      // Primary dies: monitor falls back to fast RC through the PLL
      alive = 4'he;
      n = 0;
      while (trap !== 1'b1 && n < 150) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n >= 150) timeout(obs);
      chk_min(n, 40);
      note({6'h1, 1'b0, SRC_FRC_PLL, 2'h0, 16'h0008}, {6'h3, 1'b1, 3'h7, 2'h0, 16'h0008});
      @(negedge clk_sys_i);
      note({6'h0, 22'h0}, {6'h1, 22'h0});
      alive = 4'hf;
      wr_byte(1'b0, 8'h00, 1'b1);
      note_ctl(16'h0000, 16'h0008);
      switch_to(SRC_FRC, 8'h01, OSC_FRC, 30, 200);
      note_en(5'h00, 5'h10);
      // Soft reset in mid-switch aborts it and keeps the selection
      request(SRC_LP, 8'h03);
      repeat (20) @(negedge clk_sys_i);
      soft_rst = 1'b1;
      @(negedge clk_sys_i);
      soft_rst = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      note_cur(SRC_FRC);
      note({6'h0, 22'h0}, {6'h0, 1'b1, 5'h0, 16'h0001});
      wdt_rst = 1'b1;
      @(negedge clk_sys_i);
      wdt_rst = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      note_cur(SRC_FRC);
      switch_to(SRC_LP, 8'h03, OSC_LP, 4080, 6000);
      note_ctl(16'h0002, 16'h0002);
      switch_to(SRC_FRC, 8'h03, OSC_FRC, 30, 200);
      note_en(5'h02, 5'h02);
      repeat (2) @(negedge clk_sys_i);
      end_of_test();
   end
endmodule
